/* File: hdl/rcr_regs.svh */
// Register offsets, field positions and reset values of the reset cause recorder.
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

// Byte address of the cause flag register.
`define RCR_FLAGS_OFFSET 12'h05c
// Number of implemented cause flags; bits above read as zero.
`define RCR_FLAGS_WIDTH 6
// Field positions of the cause flags.
`define RCR_BIT_EXTERNAL 0
`define RCR_BIT_POWER_ON 1
`define RCR_BIT_BROWN_OUT 2
`define RCR_BIT_WATCHDOG 3
`define RCR_BIT_SOFTWARE 4
`define RCR_BIT_REGULATOR 5
// Flag value loaded by a power-on reset: only the power-on cause is set.
`define RCR_FLAGS_POR_VALUE 6'h02
// Flag value after an external pin reset: only the external cause is set.
`define RCR_FLAGS_PIN_VALUE 6'h01
// Read value of the reserved upper bits.
`define RCR_RESERVED_VALUE 26'h0000000

`endif

/* File: hdl/rcr_pkg.sv */
// Types shared by the reset cause recorder.
package rcr_pkg;

    // Phase of the APB slave: waiting for a setup cycle, or answering.
    typedef enum logic {
        RCR_IDLE,
        RCR_ANSWER
    } rcr_apb_state_t;

    // One bit per reset cause.
    typedef logic [5:0] rcr_flags_t;

endpackage

/* File: hdl/rcr_top.sv */
// Reset cause recorder: sticky cause flags behind an APB slave.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "rcr_regs.svh"

// Overview of operation
// (RL1) Flags load from the cause of each reset.
// (RL2) External pin reset sets its flag, clears others.
// (RL3) Causes other than pin and power-on set their flag and accumulate.
// (RL4) Flags in bits 5:0, bits 31:6 read zero.
// (RL5) Software writes replace the stored flags.
module rcr_top
    import rcr_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    // Clock and resets.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_rst_n,
    // Reset cause strobes from the reset detectors, one cycle each.
    input wire logic external_pin_cause,
    input wire logic brown_out_cause,
    input wire logic watchdog_cause,
    input wire logic software_request_cause,
    input wire logic regulator_lost_cause,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Live copy of the flags for other logic.
    output logic [5:0] reset_cause_flags
);

    // Stored cause flags; they survive the bus reset.
    rcr_flags_t flags_reg;
    rcr_flags_t flags_next;
    // Cause strobes gathered into flag positions.
    rcr_flags_t cause_evt;
    // APB answer state.
    rcr_apb_state_t state_reg;
    rcr_apb_state_t state_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    // Decoded bus conditions.
    logic addr_hit;
    logic setup_cycle;
    logic access_done;
    logic flags_write;

    // Gather the cause strobes; the power-on cause comes from por_rst_n itself.
    always_comb begin
        cause_evt = '0;
        cause_evt[`RCR_BIT_EXTERNAL] = external_pin_cause;
        cause_evt[`RCR_BIT_BROWN_OUT] = brown_out_cause;
        cause_evt[`RCR_BIT_WATCHDOG] = watchdog_cause;
        cause_evt[`RCR_BIT_SOFTWARE] = software_request_cause;
        cause_evt[`RCR_BIT_REGULATOR] = regulator_lost_cause;
    end

    // Bus decode. A write takes effect only at the edge that completes the access.
    assign addr_hit = (paddr == ADDR_WIDTH'(`RCR_FLAGS_OFFSET));
    assign setup_cycle = psel && !penable;
    assign access_done = psel && penable && pready_reg;
    assign flags_write = access_done && pwrite && addr_hit;

    // Next value of the flags. The external pin outranks everything, then a
    // cause strobe is merged over a software write so that no event is lost.
    always_comb begin
        flags_next = flags_reg;
        if (cause_evt[`RCR_BIT_EXTERNAL]) begin
            // Any pin reset discards the older history.
            flags_next = `RCR_FLAGS_PIN_VALUE; // RL2
        end else if (flags_write) begin
            // Software value replaces the flags, any coincident cause still sets.
            flags_next = pwdata[5:0] | cause_evt; // RL5
        end else begin
            // Causes other than the pin accumulate.
            flags_next = flags_reg | cause_evt; // RL3
        end
    end

    // The flags are reset only at power-on, and then to the power-on cause.
    // The bus reset leaves them alone, which is the whole point of the block.
    always_ff @(posedge pclk or negedge por_rst_n) begin
        if (!por_rst_n) begin
            flags_reg <= `RCR_FLAGS_POR_VALUE; // RL1
        end else begin
            flags_reg <= flags_next; // RL1
        end
    end

    // APB answer logic: no wait state, so pready rises in the first access cycle.
    always_comb begin
        state_next = state_reg;
        prdata_next = prdata_reg;
        pready_next = pready_reg;
        pslverr_next = pslverr_reg;
        unique case (state_reg)
            RCR_IDLE: begin
                if (setup_cycle) begin
                    // Prepare the answer while the master is in setup.
                    state_next = RCR_ANSWER;
                    pready_next = 1'b1;
                    pslverr_next = !addr_hit;
                    if (addr_hit && !pwrite) begin
                        prdata_next = {`RCR_RESERVED_VALUE, flags_reg}; // RL4
                    end else begin
                        // Writes and unmapped reads return zero.
                        prdata_next = '0;
                    end
                end
            end
            RCR_ANSWER: begin
                if (access_done) begin
                    // Drop the answer so it stands only for the completing cycle.
                    state_next = RCR_IDLE;
                    pready_next = 1'b0;
                    pslverr_next = 1'b0;
                    prdata_next = '0;
                end
            end
        endcase
    end

    // APB answer registers, cleared by the bus reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RCR_IDLE;
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Outputs come straight from flip-flops.
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign reset_cause_flags = flags_reg;

    // A pin reset leaves only the external flag, whatever else happens.
    property p_pin_clears;
        @(posedge pclk) disable iff (!por_rst_n)
        external_pin_cause |=> (flags_reg == `RCR_FLAGS_PIN_VALUE);
    endproperty
    a_pin_clears: assert property (p_pin_clears) // RL2
        else $error("external cause did not clear the other flags");

    // Other causes add to the flags and keep the earlier ones.
    property p_sticky;
        @(posedge pclk) disable iff (!por_rst_n)
        (!external_pin_cause && !flags_write && (cause_evt != '0))
        |=> (flags_reg == ($past(flags_reg) | $past(cause_evt)));
    endproperty
    a_sticky: assert property (p_sticky) // RL3
        else $error("cause flags did not accumulate");

    // A watchdog cause strobe is visible in its flag in the next cycle and stays there one more cycle.
    property p_load;
        @(posedge pclk) disable iff (!por_rst_n)
        (watchdog_cause && !external_pin_cause) ##1 (!flags_write && !external_pin_cause)
        |-> flags_reg[`RCR_BIT_WATCHDOG] ##1 flags_reg[`RCR_BIT_WATCHDOG];
    endproperty
    a_load: assert property (p_load) // RL1
        else $error("watchdog cause not recorded");

    // Read answers from the flag register carry the flags in the low bits and zero above.
    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        (setup_cycle && !pwrite && addr_hit && state_reg == RCR_IDLE)
        |=> pready_reg && (prdata_reg[31:6] == '0)
            && (prdata_reg[5:0] == $past(flags_reg));
    endproperty
    a_reserved: assert property (p_reserved) // RL4
        else $error("read data wrong or reserved bits not zero");

    // A software write with no coincident cause replaces the flags.
    property p_write;
        @(posedge pclk) disable iff (!por_rst_n || !presetn)
        (flags_write && (cause_evt == '0)) |=> (flags_reg == $past(pwdata[5:0]));
    endproperty
    a_write: assert property (p_write) // RL5
        else $error("software write did not replace the flags");

    // Any other address is refused with an error and zero data, so a stray
    // pointer in software cannot be mistaken for a recorded cause.
    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (setup_cycle && !addr_hit && state_reg == RCR_IDLE)
        |=> pready_reg && pslverr_reg && (prdata_reg == '0);
    endproperty
    a_unmapped: assert property (p_unmapped) // RL4
        else $error("unmapped access not refused");

    // Scenarios worth seeing.
    property p_cov_write_clear;
        @(posedge pclk) disable iff (!presetn) flags_write && (pwdata[5:0] == '0);
    endproperty
    c_write_clear: cover property (p_cov_write_clear);

    property p_cov_two_causes;
        @(posedge pclk) disable iff (!por_rst_n)
        brown_out_cause ##[1:20] watchdog_cause;
    endproperty
    c_two_causes: cover property (p_cov_two_causes);

    property p_cov_unmapped;
        @(posedge pclk) disable iff (!presetn) access_done && pslverr_reg;
    endproperty
    c_unmapped: cover property (p_cov_unmapped);

    property p_cov_pin_over_history;
        @(posedge pclk) disable iff (!por_rst_n)
        external_pin_cause && (flags_reg[5:1] != '0);
    endproperty
    c_pin_over_history: cover property (p_cov_pin_over_history);

endmodule

/* File: verification/test_reset_cause_recorder.sv */
// Self-checking bench for the reset cause recorder.
`timescale 1ns/100ps
`include "rcr_regs.svh"

module test_reset_cause_recorder;
    import rcr_pkg::*;

    // Clock and resets, both resets low from time zero.
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic por_rst_n = 1'b0;
    // Cause strobes: 0 external, 1 brown-out, 2 watchdog, 3 software, 4 regulator.
    logic [4:0] cause = 5'h00;
    // APB master side.
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] reset_cause_flags;
    // Scoreboard counters and scratch values.
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] exp;
    logic [31:0] rd;
    logic err;

    // Design under test.
    rcr_top u_dut (
        .pclk(pclk), .presetn(presetn), .por_rst_n(por_rst_n),
        .external_pin_cause(cause[0]), .brown_out_cause(cause[1]),
        .watchdog_cause(cause[2]), .software_request_cause(cause[3]),
        .regulator_lost_cause(cause[4]), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_cause_flags(reset_cause_flags)
    );

    // Half period of 25 ns gives the 20 MHz bus clock.
    always #25 pclk = ~pclk;

    // One value comparison; every check is counted.
    task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
        total_checks++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask

    // One APB transfer; the request holds until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(32'(n), 32'h1, "pready wait");
    endtask

    // Reads the flag register and compares bus data, error and the live copy.
    task automatic reg_rd(input logic [31:0] want, input string what);
        apb(1'b0, `RCR_FLAGS_OFFSET, 32'h0);
        check(rd, want, what);
        check({31'h0, err}, 32'h0, "pslverr");
        check({26'h0, reset_cause_flags}, want, "live flags");
    endtask

    // Holds a cause strobe for exactly one cycle.
    task automatic pulse(input logic [4:0] c);
        @(posedge pclk);
        cause <= c;
        @(posedge pclk);
        cause <= 5'h00;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence; the second power-on reset shows the reload is not lost.
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_rst_n <= 1'b1;
        reg_rd(32'h02, "power-on value");
        exp = 32'h02;
        for (int i = 1; i < 5; i++) begin
            pulse(5'h01 << i);
            exp = exp | (32'h1 << (i + 1));
            reg_rd(exp, "accumulated");
        end
        $display("test sticky causes done");
        pulse(5'h01);
        reg_rd(32'h01, "external clears");
        pulse(5'h04);
        reg_rd(32'h09, "watchdog after external");
        pulse(5'h03);
        reg_rd(32'h01, "external beats coincident");
        $display("test external pin done");
        apb(1'b1, `RCR_FLAGS_OFFSET, 32'hffffffff);
        reg_rd(32'h3f, "write ones, reserved zero");
        apb(1'b1, `RCR_FLAGS_OFFSET, 32'h0);
        reg_rd(32'h00, "write zeros");
        apb(1'b1, 12'h060, 32'h2a);
        check({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b0, 12'h060, 32'h0);
        check(rd, 32'h0, "unmapped read data");
        reg_rd(32'h00, "unmapped write ignored");
        $display("test software access done");
        pulse(5'h04);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reg_rd(32'h08, "bus reset keeps flags");
        por_rst_n <= 1'b0;
        repeat (2) @(posedge pclk);
        por_rst_n <= 1'b1;
        reg_rd(32'h02, "second power-on");
        $display("test resets done");
        wrap_up();
    end

    // Watchdog: the sequence needs under 100 cycles, so 4000 means a hang.
    initial begin
        repeat (4000) @(posedge pclk);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
